// ===== pcl_pkg.sv
package pcl_pkg;
  localparam logic [1:0] BUS_W8 = 2'h0;
  localparam logic [1:0] BUS_W16 = 2'h1;
  localparam logic [1:0] BUS_W32 = 2'h2;
  localparam logic [3:0] RATIO_1 = 4'h1;
  localparam logic [3:0] RATIO_2 = 4'h2;
  localparam logic [3:0] RATIO_4 = 4'h4;
  localparam logic [3:0] RATIO_8 = 4'h8;
  localparam logic [31:0] MASK_W8 = 32'h0000_00ff;
  localparam logic [31:0] MASK_W16 = 32'h0000_ffff;
  localparam logic [31:0] MASK_W32 = 32'hffff_ffff;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_DELAY_NS = 100000;
  localparam int POR_CYCLES = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] TRAIL_EDGES = 2'h2;
  localparam int OPT_INIT_DONE_BIT = 0;

  typedef struct packed {
    logic [1:0] width;
    logic decompress;
    logic security;
  } pcl_mode_s;

  typedef struct packed {
    logic [31:0] data;
    logic last;
  } pcl_word_s;

  typedef enum logic [5:0] {
    ST_POR = 6'h01,
    ST_HOLD = 6'h02,
    ST_LOAD = 6'h04,
    ST_TRAIL = 6'h08,
    ST_INIT = 6'h10,
    ST_USER = 6'h20
  } pcl_state_e;
endpackage

// ===== pcl_loader.sv
`timescale 1ns/1ns
module pcl_loader
  import pcl_pkg::*;
#(
  parameter int POR_CYC = POR_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic load_clock_i,
  input wire logic reconfig_request_n_i,
  input wire logic [31:0] data_i,
  input wire pcl_mode_s mode_i,
  input wire logic [31:0] image_words_i,
  output logic cfg_status_n_o,
  output logic load_complete_o,
  output logic init_done_o,
  output logic init_done_oe_o,
  output logic user_io_en_o,
  output pcl_word_s word_o,
  output logic word_valid_o
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [2:0] lclk_sync_reg;
  logic [1:0] recfg_sync_reg;
  logic [31:0] data_s1_reg;
  logic [31:0] data_s2_reg;
  logic lclk_rise;
  logic lclk_fall;

  pcl_state_e state_reg, state_next;
  pcl_mode_s mode_reg, mode_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] words_reg, words_next;
  logic [3:0] phase_reg, phase_next;
  logic [1:0] trail_reg, trail_next;
  logic status_n_reg, status_n_next;
  logic done_reg, done_next;
  logic init_done_reg, init_done_next;
  logic init_oe_reg, init_oe_next;
  logic user_reg, user_next;
  pcl_word_s word_reg, word_next;
  logic valid_reg, valid_next;

  function automatic logic [3:0] word_ratio(input pcl_mode_s m);
    logic [3:0] r;
    r = RATIO_1;
    case (m.width)
      BUS_W8: r = m.decompress ? RATIO_2 : RATIO_1;
      BUS_W16: r = m.decompress ? RATIO_4 : (m.security ? RATIO_2 : RATIO_1);
      BUS_W32: r = m.decompress ? RATIO_8 : (m.security ? RATIO_4 : RATIO_1);
      default: r = RATIO_1;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] width_mask(input logic [1:0] w);
    logic [31:0] m;
    m = MASK_W32;
    case (w)
      BUS_W8: m = MASK_W8;
      BUS_W16: m = MASK_W16;
      default: m = MASK_W32;
    endcase
    return m;
  endfunction

  // release of reset is synchronous to clock_i
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // load clock, request and data pins cross through two flops; the third clock stage only feeds edge detection
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lclk_sync_reg <= 3'h0;
      recfg_sync_reg <= 2'h3;
      data_s1_reg <= 32'h0000_0000;
      data_s2_reg <= 32'h0000_0000;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], load_clock_i};
      recfg_sync_reg <= {recfg_sync_reg[0], reconfig_request_n_i};
      data_s1_reg <= data_i;
      data_s2_reg <= data_s1_reg;
    end
  end
  assign lclk_rise = lclk_sync_reg[1] & ~lclk_sync_reg[2];
  assign lclk_fall = ~lclk_sync_reg[1] & lclk_sync_reg[2];

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    words_next = words_reg;
    phase_next = phase_reg;
    trail_next = trail_reg;
    status_n_next = status_n_reg;
    done_next = done_reg;
    init_done_next = init_done_reg;
    init_oe_next = init_oe_reg;
    user_next = user_reg;
    word_next = word_reg;
    valid_next = 1'b0;
    case (state_reg)
      ST_POR: begin
        status_n_next = 1'b0;
        done_next = 1'b0;
        if (cnt_reg >= 32'(POR_CYC - 1)) begin
          state_next = ST_HOLD;
          cnt_next = 32'h0000_0000;
        end else begin
          cnt_next = cnt_reg + 32'h0000_0001;
        end
      end
      ST_HOLD: begin
        // request held low keeps the loader in reset
        status_n_next = recfg_sync_reg[1];
        done_next = 1'b0;
        words_next = 32'h0000_0000;
        phase_next = 4'h0;
        init_oe_next = 1'b0;
        init_done_next = 1'b0;
        if (recfg_sync_reg[1]) begin
          mode_next = mode_i;
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        status_n_next = 1'b1;
        if (lclk_rise) begin
          // first edge of a group takes the word, the rest are processing time
          if (phase_reg == 4'h0) begin
            word_next.data = data_s2_reg & width_mask(mode_reg.width);
            word_next.last = (words_reg + 32'h0000_0001) >= image_words_i;
            valid_next = 1'b1;
            if (words_reg == 32'h0000_0000 && data_s2_reg[OPT_INIT_DONE_BIT]) begin
              init_oe_next = 1'b1;
            end
            words_next = words_reg + 32'h0000_0001;
          end
          if (phase_reg + 4'h1 >= word_ratio(mode_reg)) begin
            phase_next = 4'h0;
            if (words_next >= image_words_i) begin
              done_next = 1'b1;
              trail_next = 2'h0;
              state_next = ST_TRAIL;
            end
          end else begin
            phase_next = phase_reg + 4'h1;
          end
        end
      end
      ST_TRAIL: begin
        if (lclk_fall) begin
          if (trail_reg + 2'h1 >= TRAIL_EDGES) begin
            cnt_next = 32'h0000_0000;
            state_next = ST_INIT;
          end else begin
            trail_next = trail_reg + 2'h1;
          end
        end
      end
      ST_INIT: begin
        if (cnt_reg >= 32'(INIT_CYCLES - 1)) begin
          init_oe_next = 1'b0;
          init_done_next = 1'b1;
          user_next = 1'b1;
          state_next = ST_USER;
        end else begin
          cnt_next = cnt_reg + 32'h0000_0001;
        end
      end
      ST_USER: begin
        // load clock edges are not looked at here
        status_n_next = 1'b1;
      end
      default: begin
        state_next = ST_POR;
        cnt_next = 32'h0000_0000;
      end
    endcase
    // a low request restarts from any state after power-on
    if (state_reg != ST_POR && !recfg_sync_reg[1]) begin
      state_next = ST_HOLD;
      status_n_next = 1'b0;
      done_next = 1'b0;
      user_next = 1'b0;
      init_oe_next = 1'b0;
      init_done_next = 1'b0;
      valid_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_POR;
      mode_reg <= '0;
      cnt_reg <= 32'h0000_0000;
      words_reg <= 32'h0000_0000;
      phase_reg <= 4'h0;
      trail_reg <= 2'h0;
      status_n_reg <= 1'b0;
      done_reg <= 1'b0;
      init_done_reg <= 1'b0;
      init_oe_reg <= 1'b0;
      user_reg <= 1'b0;
      word_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      words_reg <= words_next;
      phase_reg <= phase_next;
      trail_reg <= trail_next;
      status_n_reg <= status_n_next;
      done_reg <= done_next;
      init_done_reg <= init_done_next;
      init_oe_reg <= init_oe_next;
      user_reg <= user_next;
      word_reg <= word_next;
      valid_reg <= valid_next;
    end
  end

  assign cfg_status_n_o = status_n_reg;
  assign load_complete_o = done_reg;
  assign init_done_o = init_done_reg;
  assign init_done_oe_o = init_oe_reg;
  assign user_io_en_o = user_reg;
  assign word_o = word_reg;
  assign word_valid_o = valid_reg;
endmodule

// ===== pcl_host.sv
`timescale 1ns/1ns
module pcl_host (
  input wire logic start_i,
  input wire logic [3:0] ratio_i,
  input wire logic [31:0] words_i,
  input wire logic opt_i,
  input wire logic load_complete_i,
  output logic load_clock_o,
  output logic [31:0] data_o,
  output logic done_o
);
  initial begin
    load_clock_o = 1'b0;
    data_o = 32'h0;
    done_o = 1'b0;
  end
  always begin
    @(posedge start_i);
    done_o = 1'b0;
    for (int w = 0; w < words_i; w++) begin
      // first word carries the init-done option in bit 0
      data_o = 32'h8d3c_5a70 ^ {w[30:0], 1'b0} ^ {31'h0, opt_i && w == 0};
      for (int k = 0; k < ratio_i; k++) begin
        #62 load_clock_o = 1'b1;
        #63 load_clock_o = 1'b0;
      end
    end
    wait (load_complete_i === 1'b1);
    repeat (2) begin
      #62 load_clock_o = 1'b1;
      #63 load_clock_o = 1'b0;
    end
    data_o = ~data_o; // released bus shows no stale word
    done_o = 1'b1;
  end
endmodule

// ===== pcl_loader_props.sv
`timescale 1ns/1ns
module pcl_loader_props
  import pcl_pkg::*;
#(
  parameter int POR_CYC = POR_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic load_clock_i,
  input wire logic reconfig_request_n_i,
  input wire logic [31:0] data_i,
  input wire pcl_mode_s mode_i,
  input wire logic [31:0] image_words_i,
  input wire logic cfg_status_n_o,
  input wire logic load_complete_o,
  input wire logic init_done_o,
  input wire logic init_done_oe_o,
  input wire logic user_io_en_o,
  input wire pcl_word_s word_o,
  input wire logic word_valid_o
);
  int por_cnt;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_cnt <= 0;
    end else if (por_cnt < POR_CYC) begin
      por_cnt <= por_cnt + 1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  por_hold_a: assert property (por_cnt < POR_CYC |-> !cfg_status_n_o) else $error("por hold");
  valid_pulse_a: assert property (word_valid_o |=> !word_valid_o) else $error("valid pulse");
  done_low_load_a: assert property (word_valid_o && !word_o.last |-> !load_complete_o) else $error("done early");
  done_last_a: assert property ($rose(load_complete_o) |-> word_o.last) else $error("done no last");
  req_restart_a: assert property (!reconfig_request_n_i |-> ##[1:4] !cfg_status_n_o && !load_complete_o)
    else $error("restart");
  user_mode_a: assert property (user_io_en_o |-> load_complete_o && cfg_status_n_o) else $error("user");
  init_oe_a: assert property (init_done_oe_o |-> !init_done_o && !user_io_en_o) else $error("init drive");
  user_ignore_a: assert property (user_io_en_o |-> !word_valid_o) else $error("clock used");
  mask_w8_a: assert property (word_valid_o && mode_i.width == BUS_W8 |-> word_o.data[31:8] == 24'h0)
    else $error("mask");
  cover property (word_valid_o && word_o.last);
  cover property ($rose(init_done_oe_o));
  cover property ($rose(user_io_en_o));
endmodule
bind pcl_loader pcl_loader_props #(.POR_CYC(POR_CYC)) pcl_loader_props_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .load_clock_i(load_clock_i), .reconfig_request_n_i(reconfig_request_n_i), .data_i(data_i), .mode_i(mode_i),
  .image_words_i(image_words_i), .cfg_status_n_o(cfg_status_n_o), .load_complete_o(load_complete_o),
  .init_done_o(init_done_o), .init_done_oe_o(init_done_oe_o), .user_io_en_o(user_io_en_o), .word_o(word_o),
  .word_valid_o(word_valid_o));

// ===== pcl_loader_tb.sv
`timescale 1ns/1ns
module pcl_loader_tb;
  import pcl_pkg::*;
  typedef struct {
    pcl_mode_s mode;
    logic [3:0] ratio;
    logic [31:0] mask;
    logic opt;
  } pcl_row_s;
  pcl_row_s rows [8] = '{
    '{'{BUS_W8, 1'b0, 1'b1}, RATIO_1, MASK_W8, 1'b1}, '{'{BUS_W8, 1'b1, 1'b0}, RATIO_2, MASK_W8, 1'b1},
    '{'{BUS_W16, 1'b0, 1'b0}, RATIO_1, MASK_W16, 1'b0}, '{'{BUS_W16, 1'b0, 1'b1}, RATIO_2, MASK_W16, 1'b1},
    '{'{BUS_W16, 1'b1, 1'b1}, RATIO_4, MASK_W16, 1'b1}, '{'{BUS_W32, 1'b0, 1'b0}, RATIO_1, MASK_W32, 1'b0},
    '{'{BUS_W32, 1'b0, 1'b1}, RATIO_4, MASK_W32, 1'b1}, '{'{BUS_W32, 1'b1, 1'b0}, RATIO_8, MASK_W32, 1'b1}};
  logic clock_i, arst_n_i, load_clock, req_n, start, host_done, stat_n, cpl, ini, ini_oe, user, valid, oe_seen;
  logic opt, last_flag;
  logic [31:0] data, words, last_data;
  logic [3:0] ratio;
  pcl_mode_s mode;
  pcl_word_s word;
  int miscompares = 0, n_compared = 0, nvalid = 0, cycles = 0;
  pcl_loader #(.POR_CYC(20)) pcl_loader_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .load_clock_i(load_clock),
    .reconfig_request_n_i(req_n), .data_i(data), .mode_i(mode), .image_words_i(words), .cfg_status_n_o(stat_n),
    .load_complete_o(cpl), .init_done_o(ini), .init_done_oe_o(ini_oe), .user_io_en_o(user), .word_o(word),
    .word_valid_o(valid));
  pcl_host pcl_host_inst (.start_i(start), .ratio_i(ratio), .words_i(words), .opt_i(opt), .load_complete_i(cpl),
    .load_clock_o(load_clock), .data_o(data), .done_o(host_done));
  task automatic report_and_stop();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk1(string name, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk32(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run_host();
    start = 1'b1;
    #1 wait (host_done === 1'b1);
    start = 1'b0;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (valid === 1'b1) begin
      nvalid++;
      last_data = word.data;
      last_flag = word.last;
    end
    if (ini_oe === 1'b1) oe_seen = 1'b1;
    if (cycles == 30000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    arst_n_i = 1'b0;
    req_n = 1'b1;
    start = 1'b0;
    mode = '0;
    words = 32'h2;
    ratio = RATIO_1;
    opt = 1'b1;
    repeat (10) @(posedge clock_i);
    #1 arst_n_i = 1'b1;
    repeat (15) @(posedge clock_i);
    #1 chk1("status_n por", 1'b0, stat_n);
    foreach (rows[r]) begin
      mode = rows[r].mode;
      ratio = rows[r].ratio;
      opt = rows[r].opt;
      req_n = 1'b0;
      repeat (5) @(posedge clock_i);
      #1 chk1("status_n restart", 1'b0, stat_n);
      chk1("load_complete restart", 1'b0, cpl);
      req_n = 1'b1;
      nvalid = 0;
      oe_seen = 1'b0;
      // outputs are looked at one step after the edge that launches them
      for (int i = 0; i < 40 && stat_n !== 1'b1; i++) begin
        @(posedge clock_i);
        #1;
      end
      chk1("status_n release", 1'b1, stat_n);
      run_host();
      for (int i = 0; i < 300 && user !== 1'b1; i++) begin
        @(posedge clock_i);
        #1;
      end
      chk32("word count", 32'h2, nvalid);
      chk32("last word", 32'h8d3c_5a72 & rows[r].mask, last_data);
      chk1("last flag", 1'b1, last_flag);
      chk1("load_complete", 1'b1, cpl);
      chk1("init_done", 1'b1, ini);
      chk1("init drive seen", rows[r].opt, oe_seen);
      chk1("user_io_en", 1'b1, user);
    end
    nvalid = 0;
    run_host();
    repeat (10) @(posedge clock_i);
    #1 chk32("words in user mode", 32'h0, nvalid);
    arst_n_i = 1'b0;
    #1 chk1("status_n reset", 1'b0, stat_n);
    chk1("user_io_en reset", 1'b0, user);
    repeat (2) @(posedge clock_i);
    #1 arst_n_i = 1'b1;
    repeat (15) @(posedge clock_i);
    #1 chk1("status_n por again", 1'b0, stat_n);
    chk1("load_complete por again", 1'b0, cpl);
    for (int i = 0; i < 40 && stat_n !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk1("status_n after por", 1'b1, stat_n);
    report_and_stop();
  end
endmodule
